// file: pkg/radio_diag_port_mux_regs.vh
// Register map and field layout constants for the radio diagnostic port mux
// Contract
// - Disabled diagnostic word outputs all zero; enabled word carries selected signals.
// - Words 4..7 each have a 6-bit group selector, effective only when enabled.
// - Upper select register: one byte per word, enable top, reserved bit, selector low six.
// - Per port bit n, a 3-bit index picks a bit of diagnostic word n.
// - Per port bit invert flag drives the complement of the forwarded bit.
// - Bit-pick register: 4-bit group per bit, invert at 4n+3, index below; reset zero.
`ifndef RADIO_DIAG_PORT_MUX_REGS_VH
`define RADIO_DIAG_PORT_MUX_REGS_VH
`define DIAG_WORD_SELECT_UPPER_ADDR 32'h4000_020c
`define DIAG_BIT_PICK_INVERT_ADDR 32'h4000_0210
`define DIAG_WORD_SELECT_UPPER_RST 32'h0000_0000
`define DIAG_BIT_PICK_INVERT_RST 32'h0000_0000
`define DIAG_WORD_SELECT_UPPER_MASK 32'hbfbf_bfbf
`define DIAG_WORD_BYTE_W 8
`define DIAG_WORD_EN_POS 7
`define DIAG_WORD_SEL_W 6
`define DIAG_PICK_GROUP_W 4
`define DIAG_PICK_INV_POS 3
`define DIAG_PICK_IDX_W 3
`endif

// file: hw/radio_diag_port_mux.v
// Diagnostic port multiplexer with register access and per-bit invert
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "radio_diag_port_mux_regs.vh"
module radio_diag_port_mux (
  input wire core_clk_i,
  input wire rst_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] words_low_i,
  input wire [511:0] diag_groups_i,
  output reg [31:0] rdata_o,
  output reg [7:0] diag_port_o,
  output reg [23:0] upper_select_o
);
  // Register slot codes from the address decoder
  localparam [1:0] SLOT_NONE = 2'h0;
  localparam [1:0] SLOT_UPPER = 2'h1;
  localparam [1:0] SLOT_PICK = 2'h2;

  // Full 32-bit compare; any other address is unmapped
  function [1:0] reg_slot;
    input [31:0] addr;
    begin
      if (addr == `DIAG_WORD_SELECT_UPPER_ADDR) begin
        reg_slot = SLOT_UPPER;
      end else if (addr == `DIAG_BIT_PICK_INVERT_ADDR) begin
        reg_slot = SLOT_PICK;
      end else begin
        reg_slot = SLOT_NONE;
      end
    end
  endfunction

  // One group of eight candidate signals
  function [7:0] group_pick;
    input [511:0] groups;
    input [5:0] sel;
    begin
      group_pick = groups[sel*`DIAG_WORD_BYTE_W +: 8];
    end
  endfunction

  // Forwarded bit of a word, optionally inverted
  function port_bit;
    input [7:0] word;
    input [2:0] index;
    input invert;
    begin
      port_bit = word[index] ^ invert;
    end
  endfunction

  reg [31:0] sel_upper_reg;
  reg [31:0] sel_upper_next;
  reg [31:0] pick_reg;
  reg [31:0] pick_next;
  reg [31:0] rdata_next;
  wire [1:0] slot;
  wire [63:0] word_bus;
  wire [7:0] port_next;
  wire [23:0] upper_next;
  wire [31:0] upper_read;
  wire [31:0] pick_read;

  // Upper select register fields
  wire word4_output_enable;
  wire word5_output_enable;
  wire word6_output_enable;
  wire word7_output_enable;
  wire [5:0] word4_signal_select;
  wire [5:0] word5_signal_select;
  wire [5:0] word6_signal_select;
  wire [5:0] word7_signal_select;

  // Bit pick register fields
  wire [2:0] port_bit0_index;
  wire [2:0] port_bit1_index;
  wire [2:0] port_bit2_index;
  wire [2:0] port_bit3_index;
  wire [2:0] port_bit4_index;
  wire [2:0] port_bit5_index;
  wire [2:0] port_bit6_index;
  wire [2:0] port_bit7_index;
  wire port_bit0_invert;
  wire port_bit1_invert;
  wire port_bit2_invert;
  wire port_bit3_invert;
  wire port_bit4_invert;
  wire port_bit5_invert;
  wire port_bit6_invert;
  wire port_bit7_invert;

  // Diagnostic words as driven inside the mux
  wire [7:0] probe_word0_out;
  wire [7:0] probe_word1_out;
  wire [7:0] probe_word2_out;
  wire [7:0] probe_word3_out;
  wire [7:0] probe_word4_out;
  wire [7:0] probe_word5_out;
  wire [7:0] probe_word6_out;
  wire [7:0] probe_word7_out;

  // Fields packed for the generate loops
  wire [3:0] upper_enable;
  wire [23:0] upper_select;
  wire [23:0] bit_index;
  wire [7:0] bit_invert;

  assign slot = reg_slot(addr_i);

  assign word4_output_enable = sel_upper_reg[`DIAG_WORD_BYTE_W*0 + `DIAG_WORD_EN_POS];
  assign word5_output_enable = sel_upper_reg[`DIAG_WORD_BYTE_W*1 + `DIAG_WORD_EN_POS];
  assign word6_output_enable = sel_upper_reg[`DIAG_WORD_BYTE_W*2 + `DIAG_WORD_EN_POS];
  assign word7_output_enable = sel_upper_reg[`DIAG_WORD_BYTE_W*3 + `DIAG_WORD_EN_POS];
  assign word4_signal_select = sel_upper_reg[`DIAG_WORD_BYTE_W*0 +: `DIAG_WORD_SEL_W];
  assign word5_signal_select = sel_upper_reg[`DIAG_WORD_BYTE_W*1 +: `DIAG_WORD_SEL_W];
  assign word6_signal_select = sel_upper_reg[`DIAG_WORD_BYTE_W*2 +: `DIAG_WORD_SEL_W];
  assign word7_signal_select = sel_upper_reg[`DIAG_WORD_BYTE_W*3 +: `DIAG_WORD_SEL_W];

  assign port_bit0_index = pick_reg[`DIAG_PICK_GROUP_W*0 +: `DIAG_PICK_IDX_W];
  assign port_bit1_index = pick_reg[`DIAG_PICK_GROUP_W*1 +: `DIAG_PICK_IDX_W];
  assign port_bit2_index = pick_reg[`DIAG_PICK_GROUP_W*2 +: `DIAG_PICK_IDX_W];
  assign port_bit3_index = pick_reg[`DIAG_PICK_GROUP_W*3 +: `DIAG_PICK_IDX_W];
  assign port_bit4_index = pick_reg[`DIAG_PICK_GROUP_W*4 +: `DIAG_PICK_IDX_W];
  assign port_bit5_index = pick_reg[`DIAG_PICK_GROUP_W*5 +: `DIAG_PICK_IDX_W];
  assign port_bit6_index = pick_reg[`DIAG_PICK_GROUP_W*6 +: `DIAG_PICK_IDX_W];
  assign port_bit7_index = pick_reg[`DIAG_PICK_GROUP_W*7 +: `DIAG_PICK_IDX_W];
  assign port_bit0_invert = pick_reg[`DIAG_PICK_GROUP_W*0 + `DIAG_PICK_INV_POS];
  assign port_bit1_invert = pick_reg[`DIAG_PICK_GROUP_W*1 + `DIAG_PICK_INV_POS];
  assign port_bit2_invert = pick_reg[`DIAG_PICK_GROUP_W*2 + `DIAG_PICK_INV_POS];
  assign port_bit3_invert = pick_reg[`DIAG_PICK_GROUP_W*3 + `DIAG_PICK_INV_POS];
  assign port_bit4_invert = pick_reg[`DIAG_PICK_GROUP_W*4 + `DIAG_PICK_INV_POS];
  assign port_bit5_invert = pick_reg[`DIAG_PICK_GROUP_W*5 + `DIAG_PICK_INV_POS];
  assign port_bit6_invert = pick_reg[`DIAG_PICK_GROUP_W*6 + `DIAG_PICK_INV_POS];
  assign port_bit7_invert = pick_reg[`DIAG_PICK_GROUP_W*7 + `DIAG_PICK_INV_POS];

  assign upper_enable = {
    word7_output_enable,
    word6_output_enable,
    word5_output_enable,
    word4_output_enable
  };
  assign upper_select = {
    word7_signal_select,
    word6_signal_select,
    word5_signal_select,
    word4_signal_select
  };
  assign bit_index = {
    port_bit7_index,
    port_bit6_index,
    port_bit5_index,
    port_bit4_index,
    port_bit3_index,
    port_bit2_index,
    port_bit1_index,
    port_bit0_index
  };
  assign bit_invert = {
    port_bit7_invert,
    port_bit6_invert,
    port_bit5_invert,
    port_bit4_invert,
    port_bit3_invert,
    port_bit2_invert,
    port_bit1_invert,
    port_bit0_invert
  };

  // Read-back images; reserved bits read as zero
  assign upper_read = {
    word7_output_enable,
    1'b0,
    word7_signal_select,
    word6_output_enable,
    1'b0,
    word6_signal_select,
    word5_output_enable,
    1'b0,
    word5_signal_select,
    word4_output_enable,
    1'b0,
    word4_signal_select
  };
  assign pick_read = {
    port_bit7_invert,
    port_bit7_index,
    port_bit6_invert,
    port_bit6_index,
    port_bit5_invert,
    port_bit5_index,
    port_bit4_invert,
    port_bit4_index,
    port_bit3_invert,
    port_bit3_index,
    port_bit2_invert,
    port_bit2_index,
    port_bit1_invert,
    port_bit1_index,
    port_bit0_invert,
    port_bit0_index
  };

  // Words 0..3 arrive already selected elsewhere
  assign word_bus[31:0] = words_low_i;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : upper_words
      // Disabled word drives all zero, its selector ignored
      assign word_bus[32 + g*8 +: 8] = upper_enable[g] ?
        group_pick(diag_groups_i, upper_select[g*6 +: 6]) : 8'h00;
    end
    for (g = 0; g < 8; g = g + 1) begin : port_bits
      assign port_next[g] = port_bit(
        word_bus[g*8 +: 8],
        bit_index[g*3 +: 3],
        bit_invert[g]
      );
    end
  endgenerate

  assign probe_word0_out = word_bus[7:0];
  assign probe_word1_out = word_bus[15:8];
  assign probe_word2_out = word_bus[23:16];
  assign probe_word3_out = word_bus[31:24];
  assign probe_word4_out = word_bus[39:32];
  assign probe_word5_out = word_bus[47:40];
  assign probe_word6_out = word_bus[55:48];
  assign probe_word7_out = word_bus[63:56];

  // Words 5..7 exposed for observation
  assign upper_next = {
    probe_word7_out,
    probe_word6_out,
    probe_word5_out
  };

  always @* begin
    sel_upper_next = sel_upper_reg;
    if (wr_i && slot == SLOT_UPPER) begin
      // Reserved bit of each byte never stored
      sel_upper_next = wdata_i & `DIAG_WORD_SELECT_UPPER_MASK;
    end
  end

  always @* begin
    pick_next = pick_reg;
    if (wr_i && slot == SLOT_PICK) begin
      pick_next = wdata_i;
    end
  end

  // Read data valid only the cycle after the strobe
  always @* begin
    rdata_next = 32'h0000_0000;
    if (rd_i) begin
      case (slot)
        SLOT_UPPER: begin
          rdata_next = upper_read;
        end
        SLOT_PICK: begin
          rdata_next = pick_read;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register file
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sel_upper_reg <= `DIAG_WORD_SELECT_UPPER_RST;
      pick_reg <= `DIAG_BIT_PICK_INVERT_RST;
    end else begin
      sel_upper_reg <= sel_upper_next;
      pick_reg <= pick_next;
    end
  end

  // Read data register
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // Port outputs, one cycle behind registers and inputs
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      diag_port_o <= 8'h00;
      upper_select_o <= 24'h00_0000;
    end else begin
      diag_port_o <= port_next;
      upper_select_o <= upper_next;
    end
  end
endmodule
`default_nettype wire

// file: tb/diag_probe.sv
// Probe pins model
`timescale 1ns/1ps
`default_nettype none
module diag_probe(input wire clk_i,input wire [7:0] pins_i,output logic [7:0] seen_o);
always @(posedge clk_i) seen_o<=pins_i;
endmodule
`default_nettype wire

// file: tb/diag_chk_asserts.sv
// Port mux checker
`timescale 1ns/1ps
`default_nettype none
module diag_chk(input wire core_clk_i,rst_i,wr_i,rd_i,input wire [31:0] addr_i,wdata_i,rdata_o,
words_low_i,input wire [7:0] diag_port_o);
default clocking @(posedge core_clk_i);endclocking
default disable iff(rst_i);
sequence wp(v);wr_i&&addr_i==32'h4000_0210&&wdata_i[3:0]==v ##1 !wr_i;endsequence
sequence rb(x);wr_i&&addr_i==x ##1 rd_i&&addr_i==x;endsequence
AST_A:assert property(!$past(rd_i)|->!rdata_o)else $error("a");
AST_B:assert property(rd_i&&addr_i==32'h4000_020c|=>!(rdata_o&32'h4040_4040))else $error("b");
AST_C:assert property(rb(32'h4000_020c)|=>rdata_o==($past(wdata_i,2)&32'hbfbf_bfbf))else $error("c");
AST_D:assert property(rb(32'h4000_0210)|=>rdata_o==$past(wdata_i,2))else $error("d");
AST_E:assert property(wp(4'h5)|=>diag_port_o[0]==$past(words_low_i[5]))else $error("e");
AST_F:assert property(wp(4'hd)|=>diag_port_o[0]!=$past(words_low_i[5]))else $error("f");
AST_G:assert property($fell(rst_i)|->!diag_port_o[7:4])else $error("g");
AST_H:assert property(rd_i&&addr_i!=32'h4000_020c&&addr_i!=32'h4000_0210|=>!rdata_o)else $error("h");
endmodule
bind radio_diag_port_mux diag_chk chk(.*);
`default_nettype wire

// file: tb/tb_radio_diag_port_mux.sv
// Port mux bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin n_compared++;if((g)!==(e))begin errors++;\
$display("wrong value %s %h %h",n,e,g);end end
module tb_radio_diag_port_mux;
logic clk=0,rst=1,wr=0,rd=0;logic [31:0] a=0,d=0;wire [31:0] q;wire [7:0] pins,p;wire [23:0] us;
int errors=0,n_compared=0,t=0;localparam [31:0] U=32'h4000_020c,K=32'h4000_0210;
radio_diag_port_mux DUT(.core_clk_i(clk),.rst_i(rst),.addr_i(a),.wdata_i(d),.wr_i(wr),.rd_i(rd),
.words_low_i(32'h0101_0120),.diag_groups_i({8'h01,504'h0}),.rdata_o(q),.diag_port_o(pins),
.upper_select_o(us));
diag_probe probe(.clk_i(clk),.pins_i(pins),.seen_o(p));
initial forever #4 clk=~clk;
always @(posedge clk)if(++t>400)begin errors++;close_out;end
task automatic wrt(input [31:0] x,y);a<=x;d<=y;wr<=1;@(posedge clk);wr<=0;endtask
task automatic rdc(input [31:0] x,e);a<=x;rd<=1;@(posedge clk);rd<=0;
@(negedge clk)`CHK("rdata",e,q)@(posedge clk);endtask
task automatic pchk(input [7:0] e,input [23:0] u);repeat(4)@(negedge clk);`CHK("port",e,p)
`CHK("upper",u,us)@(posedge clk);endtask
task automatic close_out;$display("compared %0d errors %0d",n_compared,errors);
if(errors==0&&n_compared>0)
$display("Run complete: PASS");
else
$display("Run complete: FAIL");
$finish;endtask
initial begin
  repeat(6)@(posedge clk);rst<=0;
  rdc(U,0);
  rdc(K,0);
  pchk(8'h0e,24'h00_0000);
  $display("reset test done");
  wrt(U,32'hffff_ffff);
  rdc(U,32'hbfbf_bfbf);
  rdc(32'h4000_0208,0);
  wrt(K,32'h8000_000d);
  rdc(K,32'h8000_000d);
  pchk(8'h7e,24'h01_0101);
  $display("enable test done");
  wrt(U,32'h3f3f_3f3f);
  rdc(U,32'h3f3f_3f3f);
  wrt(K,32'h5);
  pchk(8'h0f,24'h00_0000);
  $display("disable test done");
  close_out;
end
endmodule
`default_nettype wire
